// ---- dv/cff_top_props.sv ----
module cff_top_props
  import cff_pkg::*;
(
  input wire logic                 i_clock,
  input wire logic                 i_rstn,
  input wire logic                 i_raw_mode,
  input wire logic [CFF_PORTS-1:0] i_frame_start,
  input wire logic [CFF_PORTS-1:0] i_frame_end,
  input wire logic [CFF_NUM_W-1:0] o_frame_number [CFF_PORTS],
  input wire logic [CFF_PORTS-1:0] o_fs_strobe,
  input wire logic [CFF_PORTS-1:0] o_fe_strobe,
  input wire logic [CFF_PORTS-1:0] o_forward_off,
  input wire logic [CFF_PORTS-1:0] o_output_select,
  input wire logic [CFF_PORTS-1:0] o_out0_ports,
  input wire logic [CFF_PORTS-1:0] o_out1_ports,
  input wire logic [1:0]           o_rate_sel,
  input wire logic                 o_rate_1600,
  input wire logic                 o_rate_800,
  input wire logic                 o_rate_400,
  input wire logic                 o_rate_reserved
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  // decode trails the stored code by one cycle
  AST_RATE_1600: assert property (
    ##1 o_rate_1600 == ($past(o_rate_sel) == CFF_RATE_1600))
    else $error("rate 1600 decode wrong");
  AST_RATE_400: assert property (
    ##1 o_rate_400 == ($past(o_rate_sel) == CFF_RATE_400))
    else $error("rate 400 decode wrong");
  AST_RATE_RSVD: assert property (
    ##1 o_rate_reserved == ($past(o_rate_sel) == CFF_RATE_RSVD))
    else $error("reserved rate decode wrong");
  // port masks follow the register a cycle later
  AST_OUT0: assert property (
    i_rstn |=> o_out0_ports == $past(~o_forward_off & ~o_output_select))
    else $error("output 0 port mask wrong");
  AST_OUT1: assert property (
    i_rstn |=> o_out1_ports == $past(~o_forward_off & o_output_select))
    else $error("output 1 port mask wrong");
  // strobes only for raw frames
  AST_FS_RAW: assert property (
    i_rstn |=> o_fs_strobe == $past(i_frame_start & {4{i_raw_mode}}))
    else $error("start strobe wrong");
  AST_FE_RAW: assert property (
    i_rstn |=> o_fe_strobe == $past(i_frame_end & {4{i_raw_mode}}))
    else $error("end strobe wrong");
  // first cycle out of reset shows the defaults
  AST_RST_FWD: assert property (
    $rose(i_rstn) |-> o_forward_off == 4'hf && o_output_select == 4'h0)
    else $error("forward defaults wrong");
  AST_RST_RATE: assert property (
    $rose(i_rstn) |-> o_rate_sel == CFF_RST_RATE && o_rate_800)
    else $error("rate default wrong");
  // end packet repeats the number of its start
  AST_NUM_PAIR: assert property (
    o_fe_strobe[0] && !o_fs_strobe[0] |-> $stable(o_frame_number[0]))
    else $error("end number differs from start");

  cover property (o_fs_strobe[0] && o_frame_number[0] == 16'h0001);
  cover property (o_rate_reserved);
  cover property (o_out1_ports != 4'h0);
endmodule : cff_top_props

bind cff_top cff_top_props i_props (
  .i_clock, .i_rstn, .i_raw_mode, .i_frame_start, .i_frame_end,
  .o_frame_number, .o_fs_strobe, .o_fe_strobe, .o_forward_off,
  .o_output_select, .o_out0_ports, .o_out1_ports, .o_rate_sel,
  .o_rate_1600, .o_rate_800, .o_rate_400, .o_rate_reserved
);

// ---- dv/tb_csi_forward_frame_config.sv ----
module tb_csi_forward_frame_config import cff_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  i_clock, i_rstn, i_raw_mode, i_bready, i_rready;
  logic                  i_awvalid, i_wvalid, i_arvalid;
  logic [CFF_ADDR_W-1:0] i_awaddr, i_araddr;
  logic [CFF_DATA_W-1:0] i_wdata, o_rdata;
  logic [3:0]            i_wstrb;
  logic [CFF_PORTS-1:0]  i_frame_start, i_frame_end, o_fs_strobe;
  logic [CFF_PORTS-1:0]  o_fe_strobe, o_forward_off, o_output_select;
  logic [CFF_PORTS-1:0]  o_out0_ports, o_out1_ports;
  logic                  o_awready, o_wready, o_bvalid, o_arready;
  logic                  o_rvalid, o_rate_1600, o_rate_800, o_rate_400;
  logic                  o_rate_reserved;
  logic [1:0]            o_bresp, o_rresp, o_rate_sel;
  logic [CFF_NUM_W-1:0]  o_frame_number [CFF_PORTS];
  int                    failures, n_checks;
  // forward values and the port masks they yield
  logic [7:0]            fv [2] = '{8'h35, 8'h0a};
  logic [7:0]            om [2] = '{8'h48, 8'ha5};

  localparam logic [7:0] a_hi   = {CFF_IDX_MAX_HIGH, 2'b00};
  localparam logic [7:0] a_lo   = {CFF_IDX_MAX_LOW, 2'b00};
  localparam logic [7:0] a_rate = {CFF_IDX_RATE, 2'b00};
  localparam logic [7:0] a_fwd  = {CFF_IDX_FWD, 2'b00};
  localparam logic [7:0] a_st   = {CFF_IDX_STATUS, 2'b00};
  localparam logic [7:0] a_num  = {CFF_IDX_NUM_BASE, 2'b00};

  cff_top i_dut (
    .i_clock, .i_rstn, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
    .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
    .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata,
    .o_rresp, .i_raw_mode, .i_frame_start, .i_frame_end, .o_frame_number,
    .o_fs_strobe, .o_fe_strobe, .o_forward_off, .o_output_select,
    .o_out0_ports, .o_out1_ports, .o_rate_sel, .o_rate_1600, .o_rate_800,
    .o_rate_400, .o_rate_reserved
  );

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic wrap_up();
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one edge of a bounded wait; a hang ends the run
  task automatic step(inout int n);
    @(posedge i_clock);
    n++;
    if (n > 200) begin
      failures++;
      wrap_up();
    end
  endtask : step

  // each channel released on the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    i_awvalid <= 1'b1;
    i_awaddr  <= a;
    i_wvalid  <= 1'b1;
    i_wdata   <= {24'h0, d};
    i_bready  <= 1'b1;
    do begin
      step(n);
      if (o_awready === 1'b1) i_awvalid <= 1'b0;
      if (o_wready === 1'b1) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    chk(o_bresp, er);
    // extra edge lets the one-cycle decodes settle
    @(posedge i_clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    i_arvalid <= 1'b1;
    i_araddr  <= a;
    i_rready  <= 1'b1;
    do begin
      step(n);
      if (o_arready === 1'b1) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    chk(o_rdata, ed);
    chk(o_rresp, er);
    @(posedge i_clock);
  endtask : rd

  // start pulse, end pulse, then both packets' numbers
  task automatic frm(input int p, input logic raw, input logic [15:0] en);
    i_raw_mode       <= raw;
    i_frame_start[p] <= 1'b1;
    @(posedge i_clock);
    i_frame_start[p] <= 1'b0;
    i_frame_end[p]   <= 1'b1;
    @(posedge i_clock);
    i_frame_end[p] <= 1'b0;
    chk(o_fs_strobe[p], raw);
    chk(o_frame_number[p], en);
    @(posedge i_clock);
    chk(o_fe_strobe[p], raw);
    chk(o_frame_number[p], en);
  endtask : frm

  initial begin
    i_rstn = 1'b0;
    i_raw_mode = 1'b0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
    {i_awaddr, i_araddr, i_wdata} = '0;
    i_wstrb = 4'hf;
    {i_frame_start, i_frame_end} = 8'h0;
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    // defaults after reset
    rd(a_hi, 32'h0, CFF_RESP_OKAY);
    rd(a_lo, 32'h4, CFF_RESP_OKAY);
    rd(a_rate, 32'h2, CFF_RESP_OKAY);
    rd(a_fwd, 32'hf0, CFF_RESP_OKAY);
    chk({o_forward_off, o_output_select, 3'h0, o_rate_800}, 12'hf01);
    // default limit four wraps back to one
    for (int k = 0; k < 5; k++) frm(0, 1'b1, 16'(k % 4 + 1));
    frm(1, 1'b1, 16'h1);
    frm(1, 1'b0, 16'h1);
    rd(a_num, 32'h1, CFF_RESP_OKAY);
    // limit 0x0102 spans both bytes
    wr(a_hi, 8'h01, CFF_RESP_OKAY);
    wr(a_lo, 8'h02, CFF_RESP_OKAY);
    for (int k = 1; k < 260; k++) frm(2, 1'b1, 16'(k > 258 ? 1 : k));
    wr(a_hi, 8'h00, CFF_RESP_OKAY);
    wr(a_lo, 8'h00, CFF_RESP_OKAY);
    for (int k = 0; k < 2; k++) frm(3, 1'b1, 16'h0);
    // every rate code; upper bits read back as zero
    for (int c = 0; c < 4; c++) begin
      wr(a_rate, 8'hfc | 8'(c), CFF_RESP_OKAY);
      rd(a_rate, 32'(c), CFF_RESP_OKAY);
      chk({o_rate_400, o_rate_800, o_rate_reserved, o_rate_1600},
          4'h1 << c);
    end
    // disable first keeping the map, remap, then enable
    for (int i = 0; i < 2; i++) begin
      wr(a_fwd, 8'hf0 | (i == 0 ? 8'h00 : fv[0]), CFF_RESP_OKAY);
      wr(a_fwd, 8'hf0 | fv[i], CFF_RESP_OKAY);
      wr(a_fwd, fv[i], CFF_RESP_OKAY);
      chk({o_forward_off, o_output_select}, fv[i]);
      chk({o_out1_ports, o_out0_ports}, om[i]);
      rd(a_st, 32'h0, CFF_RESP_OKAY);
    end
    // remap of live ports is flagged, then cleared by writing ones
    wr(a_fwd, 8'h05, CFF_RESP_OKAY);
    rd(a_st, 32'hf, CFF_RESP_OKAY);
    wr(a_st, 8'h0f, CFF_RESP_OKAY);
    rd(a_st, 32'h0, CFF_RESP_OKAY);
    // unmapped place refused, nothing stored
    wr(8'h00, 8'h5a, CFF_RESP_SLVERR);
    rd(8'h00, 32'h0, CFF_RESP_SLVERR);
    rd(a_fwd, 32'h05, CFF_RESP_OKAY);
    wrap_up();
  end
endmodule : tb_csi_forward_frame_config

// ---- logic/cff_frame_counter.sv ----
// per-port frame numbering, one instance per receive port
module cff_frame_counter
  import cff_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_rstn,
  input  wire logic [CFF_NUM_W-1:0] i_max_count,
  input  wire logic                 i_raw_mode,
  input  wire logic                 i_frame_start,
  input  wire logic                 i_frame_end,
  output logic      [CFF_NUM_W-1:0] o_number,
  output logic                      o_start_strobe,
  output logic                      o_end_strobe
);

  logic [CFF_NUM_W-1:0] count;
  logic [CFF_NUM_W-1:0] next_count;
  logic                 raw_start;
  logic                 wrap;

  // only frames built in raw mode are numbered
  assign raw_start = i_frame_start && i_raw_mode;
  // >= also catches a limit lowered below the running count
  assign wrap = (count == '0) || (count >= i_max_count);
  assign next_count = (i_max_count == '0) ? '0 :
                      wrap ? CFF_NUM_W'(1) : count + CFF_NUM_W'(1);

  // number is held from frame start through the matching end
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      count          <= '0;
      o_number       <= '0;
      o_start_strobe <= 1'b0;
      o_end_strobe   <= 1'b0;
    end else begin
      if (raw_start) begin
        count    <= next_count;
        o_number <= next_count;
      end
      o_start_strobe <= raw_start;
      o_end_strobe   <= i_frame_end && i_raw_mode;
    end
  end

endmodule : cff_frame_counter

// ---- logic/cff_pkg.sv ----
package cff_pkg;

  // bus shape
  localparam int unsigned CFF_ADDR_W = 8;
  localparam int unsigned CFF_DATA_W = 32;
  localparam int unsigned CFF_PORTS  = 4;
  localparam int unsigned CFF_NUM_W  = 16;

  // register indices; byte address is four times the index
  localparam logic [5:0] CFF_IDX_MAX_HIGH = 6'h1d;
  localparam logic [5:0] CFF_IDX_MAX_LOW  = 6'h1e;
  localparam logic [5:0] CFF_IDX_RATE     = 6'h1f;
  localparam logic [5:0] CFF_IDX_FWD      = 6'h20;
  localparam logic [5:0] CFF_IDX_STATUS   = 6'h28;
  localparam logic [5:0] CFF_IDX_NUM_BASE = 6'h29;

  // reset values
  localparam logic [7:0] CFF_RST_MAX_HIGH = 8'h00;
  localparam logic [7:0] CFF_RST_MAX_LOW  = 8'h04;
  localparam logic [1:0] CFF_RST_RATE     = 2'h2;
  localparam logic [7:0] CFF_RST_FWD      = 8'hf0;

  // field positions
  localparam int unsigned CFF_FWD_OFF_LSB = 4;
  localparam int unsigned CFF_MAP_LSB     = 0;
  localparam int unsigned CFF_RATE_LSB    = 0;
  localparam int unsigned CFF_RATE_W      = 2;

  // transmitter rate codes
  localparam logic [1:0] CFF_RATE_1600 = 2'h0;
  localparam logic [1:0] CFF_RATE_RSVD = 2'h1;
  localparam logic [1:0] CFF_RATE_800  = 2'h2;
  localparam logic [1:0] CFF_RATE_400  = 2'h3;

  // bus responses
  localparam logic [1:0] CFF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CFF_RESP_SLVERR = 2'h2;

endpackage : cff_pkg

// ---- logic/cff_top.sv ----
// Overview of operation
// - raw frames carry 16-bit number in start, end
// - zero limit means frame number always zero
// - number counts 1 to limit, then wraps
// - limit built from high and low bytes
// - rate codes: 00 1600, 10 800, 11 400
// - rate select resets to two, 800 Mbps
// - bits 7..4 disable forwarding per port
// - forwarding register resets to f0
// - bits 3..0 pick output 0 or 1
// - only raw-mode frames are numbered
module cff_top
  import cff_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rstn,
  // axi4-lite write address
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [CFF_ADDR_W-1:0] i_awaddr,
  // axi4-lite write data
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  input  wire logic [CFF_DATA_W-1:0] i_wdata,
  input  wire logic [3:0]            i_wstrb,
  // axi4-lite write response
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  output logic      [1:0]            o_bresp,
  // axi4-lite read address
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  input  wire logic [CFF_ADDR_W-1:0] i_araddr,
  // axi4-lite read data
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  output logic      [CFF_DATA_W-1:0] o_rdata,
  output logic      [1:0]            o_rresp,
  // frame events from the receive ports
  input  wire logic                  i_raw_mode,
  input  wire logic [CFF_PORTS-1:0]  i_frame_start,
  input  wire logic [CFF_PORTS-1:0]  i_frame_end,
  output logic      [CFF_NUM_W-1:0]  o_frame_number [CFF_PORTS],
  output logic      [CFF_PORTS-1:0]  o_fs_strobe,
  output logic      [CFF_PORTS-1:0]  o_fe_strobe,
  // forwarding controls
  output logic      [CFF_PORTS-1:0]  o_forward_off,
  output logic      [CFF_PORTS-1:0]  o_output_select,
  output logic      [CFF_PORTS-1:0]  o_out0_ports,
  output logic      [CFF_PORTS-1:0]  o_out1_ports,
  // transmitter rate
  output logic      [CFF_RATE_W-1:0] o_rate_sel,
  output logic                       o_rate_1600,
  output logic                       o_rate_800,
  output logic                       o_rate_400,
  output logic                       o_rate_reserved
);

  // ---- register state
  logic [7:0]            frame_limit_upper_byte;
  logic [7:0]            frame_limit_lower_byte;
  logic [CFF_RATE_W-1:0] rate_sel;
  logic [7:0]            fwd_ctl;
  logic [CFF_PORTS-1:0]  map_warn;

  // ---- write channel state
  logic                  aw_held;
  logic                  w_held;
  logic [CFF_ADDR_W-1:0] aw_addr;
  logic [7:0]            w_byte;
  logic                  w_lane0;

  // ---- derived wires
  logic                  aw_take;
  logic                  w_take;
  logic                  wr_fire;
  logic                  next_aw_held;
  logic                  next_w_held;
  logic                  next_bvalid;
  logic                  rd_fire;
  logic                  next_rvalid;
  logic [5:0]            wr_idx;
  logic [5:0]            rd_idx;
  logic                  wr_aligned;
  logic                  rd_aligned;
  logic                  wr_max_high;
  logic                  wr_max_low;
  logic                  wr_rate;
  logic                  wr_fwd;
  logic                  wr_status;
  logic                  wr_hit;
  logic                  wr_byte_en;
  logic [CFF_PORTS-1:0]  rd_num_hit;
  logic                  rd_hit;
  logic [CFF_DATA_W-1:0] rd_word;
  logic [CFF_DATA_W-1:0] rd_num_word;
  logic [CFF_NUM_W-1:0]  max_count;
  logic [CFF_PORTS-1:0]  map_changed;
  logic [CFF_PORTS-1:0]  map_set;
  logic [CFF_PORTS-1:0]  map_clr;
  logic [CFF_PORTS-1:0]  fwd_off;
  logic [CFF_PORTS-1:0]  out_select;

  // ---- write handshake: address and data taken in either order
  assign aw_take = i_awvalid && o_awready;
  assign w_take  = i_wvalid && o_wready;
  assign wr_fire = aw_held && w_held && !o_bvalid;

  assign next_aw_held = (aw_held && !wr_fire) || aw_take;
  assign next_w_held  = (w_held && !wr_fire) || w_take;
  assign next_bvalid  = wr_fire || (o_bvalid && !i_bready);

  // ---- read handshake: one read outstanding at a time
  assign rd_fire     = i_arvalid && o_arready;
  assign next_rvalid = rd_fire || (o_rvalid && !i_rready);

  // ---- write decode on the captured address
  assign wr_idx      = aw_addr[7:2];
  assign wr_aligned  = (aw_addr[1:0] == 2'h0);
  assign wr_max_high = wr_aligned && (wr_idx == CFF_IDX_MAX_HIGH);
  assign wr_max_low  = wr_aligned && (wr_idx == CFF_IDX_MAX_LOW);
  assign wr_rate     = wr_aligned && (wr_idx == CFF_IDX_RATE);
  assign wr_fwd      = wr_aligned && (wr_idx == CFF_IDX_FWD);
  assign wr_status   = wr_aligned && (wr_idx == CFF_IDX_STATUS);
  assign wr_hit      = wr_max_high || wr_max_low || wr_rate ||
                       wr_fwd || wr_status;
  // registers are one byte wide, so only lane 0 stores
  assign wr_byte_en  = wr_fire && w_lane0;

  // ---- field views of the forwarding register
  assign fwd_off    = fwd_ctl[CFF_FWD_OFF_LSB +: CFF_PORTS];
  assign out_select = fwd_ctl[CFF_MAP_LSB +: CFF_PORTS];

  // ---- 16-bit limit from the two bytes
  assign max_count = {frame_limit_upper_byte,
                      frame_limit_lower_byte};

  // ---- remapping a port that still forwards is flagged for software;
  // the hardware cannot stop the host doing it, only report it
  assign map_changed = (w_byte[CFF_MAP_LSB +: CFF_PORTS] ^ out_select);
  assign map_set = (wr_byte_en && wr_fwd) ?
                   (map_changed & ~fwd_off) : '0;
  assign map_clr = (wr_byte_en && wr_status) ?
                   w_byte[CFF_PORTS-1:0] : '0;

  // ---- read decode straight from the bus address
  assign rd_idx     = i_araddr[7:2];
  assign rd_aligned = (i_araddr[1:0] == 2'h0);

  // per-port frame number readback, one word per port
  genvar g;
  generate
    for (g = 0; g < CFF_PORTS; g++) begin : g_port
      assign rd_num_hit[g] = rd_aligned &&
             (rd_idx == CFF_IDX_NUM_BASE + 6'(g));

      cff_frame_counter u_counter (
        .i_clock        (i_clock),
        .i_rstn         (i_rstn),
        .i_max_count    (max_count),
        .i_raw_mode     (i_raw_mode),
        .i_frame_start  (i_frame_start[g]),
        .i_frame_end    (i_frame_end[g]),
        .o_number       (o_frame_number[g]),
        .o_start_strobe (o_fs_strobe[g]),
        .o_end_strobe   (o_fe_strobe[g])
      );
    end
  endgenerate

  // one-hot select of the frame number words
  always_comb begin
    rd_num_word = '0;
    for (int p = 0; p < CFF_PORTS; p++) begin
      if (rd_num_hit[p]) begin
        rd_num_word = {16'h0000, o_frame_number[p]};
      end
    end
  end

  assign rd_hit = (|rd_num_hit) || (rd_aligned &&
                  ((rd_idx == CFF_IDX_MAX_HIGH) ||
                   (rd_idx == CFF_IDX_MAX_LOW) ||
                   (rd_idx == CFF_IDX_RATE) ||
                   (rd_idx == CFF_IDX_FWD) ||
                   (rd_idx == CFF_IDX_STATUS)));

  // reserved rate bits 7..2 read as zero
  assign rd_word =
    !rd_aligned ? '0 :
    (rd_idx == CFF_IDX_MAX_HIGH) ? {24'h0, frame_limit_upper_byte} :
    (rd_idx == CFF_IDX_MAX_LOW)  ? {24'h0, frame_limit_lower_byte} :
    (rd_idx == CFF_IDX_RATE)     ? {30'h0, rate_sel} :
    (rd_idx == CFF_IDX_FWD)      ? {24'h0, fwd_ctl} :
    (rd_idx == CFF_IDX_STATUS)   ? {28'h0, map_warn} :
    rd_num_word;

  // ---- write channel capture
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_byte  <= '0;
      w_lane0 <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      if (aw_take) begin
        aw_addr <= i_awaddr;
      end
      if (w_take) begin
        w_byte  <= i_wdata[7:0];
        w_lane0 <= i_wstrb[0];
      end
    end
  end

  // ---- ready and response flops; ready drops while a reply waits
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= CFF_RESP_OKAY;
    end else begin
      o_awready <= !next_aw_held && !next_bvalid;
      o_wready  <= !next_w_held && !next_bvalid;
      o_bvalid  <= next_bvalid;
      if (wr_fire) begin
        o_bresp <= wr_hit ? CFF_RESP_OKAY : CFF_RESP_SLVERR;
      end
    end
  end

  // ---- read answer one cycle after the address is taken
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= CFF_RESP_OKAY;
    end else begin
      o_arready <= !next_rvalid;
      o_rvalid  <= next_rvalid;
      if (rd_fire) begin
        o_rdata <= rd_word;
        o_rresp <= rd_hit ? CFF_RESP_OKAY : CFF_RESP_SLVERR;
      end
    end
  end

  // ---- configuration registers
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      frame_limit_upper_byte <= CFF_RST_MAX_HIGH;
      frame_limit_lower_byte <= CFF_RST_MAX_LOW;
      rate_sel               <= CFF_RST_RATE;
      fwd_ctl                <= CFF_RST_FWD;
    end else if (wr_byte_en) begin
      if (wr_max_high) begin
        frame_limit_upper_byte <= w_byte;
      end
      if (wr_max_low) begin
        frame_limit_lower_byte <= w_byte;
      end
      if (wr_rate) begin
        rate_sel <= w_byte[CFF_RATE_LSB +: CFF_RATE_W];
      end
      if (wr_fwd) begin
        fwd_ctl <= w_byte;
      end
    end
  end

  // ---- sticky remap warning; a new event beats a same-cycle clear
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      map_warn <= '0;
    end else begin
      map_warn <= (map_warn & ~map_clr) | map_set;
    end
  end

  // ---- rate decode, flopped so every output leaves a register
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rate_1600     <= 1'b0;
      o_rate_800      <= 1'b1;
      o_rate_400      <= 1'b0;
      o_rate_reserved <= 1'b0;
    end else begin
      o_rate_1600     <= (rate_sel == CFF_RATE_1600);
      o_rate_800      <= (rate_sel == CFF_RATE_800);
      o_rate_400      <= (rate_sel == CFF_RATE_400);
      o_rate_reserved <= (rate_sel == CFF_RATE_RSVD);
    end
  end

  // ---- per-output port masks: enabled and mapped there
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_out0_ports <= '0;
      o_out1_ports <= '0;
    end else begin
      o_out0_ports <= ~fwd_off & ~out_select;
      o_out1_ports <= ~fwd_off & out_select;
    end
  end

  // field views come straight from the register flops
  assign o_forward_off   = fwd_off;
  assign o_output_select = out_select;
  assign o_rate_sel      = rate_sel;

endmodule : cff_top
